// ===== lps_ctrl.sv
// 1:N protection switching controller
// Function
// [R01] reversion delay 0.5-12 min, default 5, revertive; the code resets to non-revertive with CTRL_REVERT clear
// [R02] reversion starts after conditions clear
// [R03] reversion expiry swaps roles back
// [R04] verification guard selectable 500 ms to 1 s
// [R05] force sets k1 force and starts guard; the code refuses it under lockout with the protect port failed
// [R06] unacked force cancelled at guard expiry
// [R07] recovery guard selectable 0-10 s, default 1
// [R08] defect declared clear after recovery guard
// [R09] detection guard selectable 0-5 s, default 1
// [R10] detection guard expiry switches to protect port; the code does not switch under lockout or with the protect port failed
// [R11] one protect port guards selected working ports
// [R12] timers share a tick and restart on recurrence
// [R13] non-revertive keeps traffic on protect
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module lps_ctrl
    import lps_pkg::*;
#(
    parameter int unsigned NWORK        = 4,
    parameter int unsigned TICK_CYCLES  = TICK_CYC
) (
    // clock and reset
    input  wire logic              sys_clk_i,
    input  wire logic              sys_rst_i,
    // axi4-lite slave
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // line defects from the ports
    input  wire lps_defect_s [NWORK-1:0] work_defect_i,
    input  wire lps_defect_s       prot_defect_i,
    // k1 bytes to and from the far end
    input  wire logic [7:0]        rx_k1_i,
    output logic [7:0]             tx_k1_o,
    // traffic selector
    output logic                   sel_prot_o
);
    // synchronisers for pin inputs
    lps_defect_s [NWORK-1:0] wdef_s1_reg;
    lps_defect_s [NWORK-1:0] wdef_reg;
    lps_defect_s             pdef_s1_reg;
    lps_defect_s             pdef_reg;
    logic [7:0]              k1_s1_reg;
    logic [7:0]              k1_reg;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            wdef_s1_reg <= '0;
            wdef_reg    <= '0;
            pdef_s1_reg <= '0;
            pdef_reg    <= '0;
            k1_s1_reg   <= 8'h00;
            k1_reg      <= 8'h00;
        end else begin
            wdef_s1_reg <= work_defect_i;
            wdef_reg    <= wdef_s1_reg;
            pdef_s1_reg <= prot_defect_i;
            pdef_reg    <= pdef_s1_reg;
            k1_s1_reg   <= rx_k1_i;
            k1_reg      <= k1_s1_reg;
        end
    end

    // software registers
    logic [1:0]       ctrl_reg,  ctrl_next;
    logic [TMW-1:0]   rev_reg,   rev_next;
    logic [TMW-1:0]   ver_reg,   ver_next;
    logic [TMW-1:0]   rec_reg,   rec_next;
    logic [TMW-1:0]   det_reg,   det_next;
    logic [NWORK-1:0] wmask_reg, wmask_next;
    // bus handshake state
    logic             aw_reg,    aw_next;
    logic             w_reg,     w_next;
    logic [7:0]       awa_reg,   awa_next;
    logic [31:0]      wd_reg,    wd_next;
    logic             bv_reg,    bv_next;
    logic [1:0]       br_reg,    br_next;
    logic             rv_reg,    rv_next;
    logic [31:0]      rd_reg,    rd_next;
    logic [1:0]       rr_reg,    rr_next;
    // switching state
    logic             prot_reg,  prot_next;
    logic             decl_reg,  decl_next;
    logic             pend_reg,  pend_next;
    logic             fact_reg,  fact_next;
    logic             drop_reg,  drop_next;
    // decoded strobes and status
    logic             wr_go, force_wr, clear_wr, drop_clr;
    logic             raw_fail, prot_fail, acked;
    logic             det_done, rec_done, rev_done, ver_done;
    logic             det_run, rec_run, rev_run, ver_run;
    logic             tick;
    logic [7:0]       status;

    // clamp a written interval into range
    function automatic logic [TMW-1:0] clamp(
        input logic [31:0] v, input logic [TMW-1:0] lo,
        input logic [TMW-1:0] hi);
        logic [TMW-1:0] r;
        if (v > 32'(hi)) r = hi;
        else if (v < 32'(lo)) r = lo;
        else r = v[TMW-1:0];
        return r;
    endfunction : clamp

    // any selected working port failed
    always_comb begin
        raw_fail = 1'b0;
        for (int i = 0; i < NWORK; i++) begin
            raw_fail = raw_fail | (wmask_reg[i] & |wdef_reg[i]); // R11
        end
        prot_fail = |pdef_reg;
        acked     = (k1_reg[7:4] == K1_REQ_FORCE);
        status    = {drop_reg, rev_run, prot_fail, raw_fail,
                     decl_reg, fact_reg, pend_reg, prot_reg};
    end

    // tick and the four timers
    lps_tick #(.CYC(TICK_CYCLES)) u_tick (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_o    (tick)                                        // R12
    );
    lps_timer u_det (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (tick),
        .arm_i     (raw_fail && !decl_reg),                      // R10
        .limit_i   (det_reg),
        .done_o    (det_done),
        .run_o     (det_run)
    );
    lps_timer u_rec (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (tick),
        .arm_i     (!raw_fail && decl_reg),                      // R08
        .limit_i   (rec_reg),
        .done_o    (rec_done),
        .run_o     (rec_run)
    );
    lps_timer u_rev (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (tick),
        .arm_i     (ctrl_reg[CTRL_REVERT] && prot_reg && !decl_reg
                    && !raw_fail && !pend_reg && !fact_reg),     // R02 R13
        .limit_i   (rev_reg),
        .done_o    (rev_done),
        .run_o     (rev_run)
    );
    lps_timer u_ver (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (tick),
        .arm_i     (pend_reg),
        .limit_i   (ver_reg),
        .done_o    (ver_done),
        .run_o     (ver_run)
    );

    // axi4-lite channels and register updates
    always_comb begin
        aw_next = aw_reg;  w_next = w_reg;
        awa_next = awa_reg; wd_next = wd_reg;
        bv_next = bv_reg;  br_next = br_reg;
        rv_next = rv_reg;  rd_next = rd_reg; rr_next = rr_reg;
        ctrl_next = ctrl_reg; rev_next = rev_reg; ver_next = ver_reg;
        rec_next = rec_reg; det_next = det_reg; wmask_next = wmask_reg;
        force_wr = 1'b0; clear_wr = 1'b0; drop_clr = 1'b0;
        s_axi_awready = !aw_reg && !bv_reg;
        s_axi_wready  = !w_reg && !bv_reg;
        s_axi_arready = !rv_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_next  = 1'b1;
            awa_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_next  = 1'b1;
            wd_next = s_axi_wdata;
        end
        wr_go = aw_reg && w_reg;
        if (wr_go) begin
            aw_next = 1'b0;
            w_next  = 1'b0;
            bv_next = 1'b1;
            br_next = RESP_OKAY;
            unique case (awa_reg)
                OFS_CTRL:  ctrl_next  = wd_reg[1:0];
                OFS_REV:   rev_next   = clamp(wd_reg, REV_MIN_TK,
                                              REV_MAX_TK);       // R01
                OFS_VER:   ver_next   = clamp(wd_reg, VER_MIN_TK,
                                              VER_MAX_TK);       // R04
                OFS_REC:   rec_next   = clamp(wd_reg, '0,
                                              REC_MAX_TK);       // R07
                OFS_DET:   det_next   = clamp(wd_reg, '0,
                                              DET_MAX_TK);       // R09
                OFS_WMASK: wmask_next = wd_reg[NWORK-1:0];
                OFS_CMD: begin
                    force_wr = wd_reg[CMD_FORCE];
                    clear_wr = wd_reg[CMD_CLEAR];
                end
                OFS_STAT:  drop_clr   = wd_reg[ST_DROP];
                default:   br_next    = RESP_SLVERR;
            endcase
        end
        if (bv_reg && s_axi_bready) begin
            bv_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rv_next = 1'b1;
            rr_next = RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_CTRL:  rd_next = 32'(ctrl_reg);
                OFS_REV:   rd_next = 32'(rev_reg);
                OFS_VER:   rd_next = 32'(ver_reg);
                OFS_REC:   rd_next = 32'(rec_reg);
                OFS_DET:   rd_next = 32'(det_reg);
                OFS_WMASK: rd_next = 32'(wmask_reg);
                OFS_CMD:   rd_next = 32'h0;
                OFS_STAT:  rd_next = 32'(status);
                default: begin
                    rd_next = 32'h0;
                    rr_next = RESP_SLVERR;
                end
            endcase
        end else if (rv_reg && s_axi_rready) begin
            rv_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            aw_reg <= 1'b0; w_reg <= 1'b0; awa_reg <= 8'h00;
            wd_reg <= 32'h0; bv_reg <= 1'b0; br_reg <= RESP_OKAY;
            rv_reg <= 1'b0; rd_reg <= 32'h0; rr_reg <= RESP_OKAY;
            ctrl_reg  <= CTRL_RST;
            rev_reg   <= REV_DEF_TK;                             // R01
            ver_reg   <= VER_MAX_TK;
            rec_reg   <= REC_DEF_TK;                             // R07
            det_reg   <= DET_DEF_TK;                             // R09
            wmask_reg <= '1;
        end else begin
            aw_reg <= aw_next; w_reg <= w_next; awa_reg <= awa_next;
            wd_reg <= wd_next; bv_reg <= bv_next; br_reg <= br_next;
            rv_reg <= rv_next; rd_reg <= rd_next; rr_reg <= rr_next;
            ctrl_reg  <= ctrl_next;
            rev_reg   <= rev_next;
            ver_reg   <= ver_next;
            rec_reg   <= rec_next;
            det_reg   <= det_next;
            wmask_reg <= wmask_next;
        end
    end

    // switching and force request state
    always_comb begin
        prot_next = prot_reg; decl_next = decl_reg;
        pend_next = pend_reg; fact_next = fact_reg;
        drop_next = drop_reg && !drop_clr;
        if (det_done) begin
            decl_next = 1'b1;
            if (!ctrl_reg[CTRL_LOCKOUT] && !prot_fail) begin
                prot_next = 1'b1;                                // R10
            end
        end
        if (rec_done) begin
            decl_next = 1'b0;                                    // R08
        end
        if (rev_done) begin
            prot_next = 1'b0;                                    // R03
        end
        if (clear_wr) begin
            pend_next = 1'b0;
            fact_next = 1'b0;
        end
        if (force_wr && !pend_reg && !fact_reg
            && (!ctrl_reg[CTRL_LOCKOUT] || !prot_fail)) begin
            pend_next = 1'b1;                                    // R05
        end
        if (pend_reg && acked) begin
            pend_next = 1'b0;
            fact_next = 1'b1;
            prot_next = 1'b1;
        end else if (ver_done) begin
            pend_next = 1'b0;                                    // R06
            drop_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            prot_reg <= 1'b0; decl_reg <= 1'b0;
            pend_reg <= 1'b0; fact_reg <= 1'b0; drop_reg <= 1'b0;
        end else begin
            prot_reg <= prot_next; decl_reg <= decl_next;
            pend_reg <= pend_next; fact_reg <= fact_next;
            drop_reg <= drop_next;
        end
    end

    // bus and line outputs
    assign s_axi_bvalid = bv_reg;
    assign s_axi_bresp  = br_reg;
    assign s_axi_rvalid = rv_reg;
    assign s_axi_rdata  = rd_reg;
    assign s_axi_rresp  = rr_reg;
    assign sel_prot_o   = prot_reg;
    assign tx_k1_o      = {(pend_reg || fact_reg) ? K1_REQ_FORCE
                           : K1_REQ_NONE, 3'h0, prot_reg};       // R05

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_rev_range;
        rev_reg >= REV_MIN_TK && rev_reg <= REV_MAX_TK;
    endproperty
    a_rev_range: assert property (p_rev_range) // R01
        else $error("reversion range");
    property p_rev_clear;
        rev_run |-> !decl_reg && !raw_fail;
    endproperty
    a_rev_clear: assert property (p_rev_clear) // R02
        else $error("early reversion");
    property p_rev_swap;
        rev_done && !det_done |=> !prot_reg;
    endproperty
    a_rev_swap: assert property (p_rev_swap) // R03
        else $error("no reversion");
    property p_ver_range;
        ver_reg >= VER_MIN_TK && ver_reg <= VER_MAX_TK;
    endproperty
    a_ver_range: assert property (p_ver_range) // R04
        else $error("verify range");
    property p_force_k1;
        pend_reg |-> tx_k1_o[7:4] == K1_REQ_FORCE;
    endproperty
    a_force_k1: assert property (p_force_k1) // R05
        else $error("force not on k1");
    property p_ver_cancel;
        pend_reg && ver_done && !acked |=> !pend_reg && drop_reg;
    endproperty
    a_ver_cancel: assert property (p_ver_cancel) // R06
        else $error("force not dropped");
    property p_rec_range;
        rec_reg <= REC_MAX_TK && det_reg <= DET_MAX_TK;
    endproperty
    a_rec_range: assert property (p_rec_range) // R07
        else $error("guard range");
    property p_det_switch;
        det_done && !ctrl_reg[CTRL_LOCKOUT] && !prot_fail
            |=> prot_reg && decl_reg;
    endproperty
    a_det_switch: assert property (p_det_switch) // R10
        else $error("no switch");
    property p_nonrev;
        !ctrl_reg[CTRL_REVERT] |-> !rev_run;
    endproperty
    a_nonrev: assert property (p_nonrev) // R13
        else $error("reversion when off");
endmodule : lps_ctrl

// ===== lps_pkg.sv
// package: constants and types of the protection switch controller
package lps_pkg;
    // clock and common tick
    localparam int unsigned CLK_HZ    = 25_000_000;
    localparam int unsigned TICK_MS   = 100;
    localparam int unsigned TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TMW       = 13;
    // interval limits, then in ticks
    localparam real REV_MIN_MIN = 0.5;
    localparam real REV_MAX_MIN = 12.0;
    localparam real REV_DEF_MIN = 5.0;
    localparam int unsigned VER_MIN_MS = 500;
    localparam int unsigned VER_MAX_S  = 1;
    localparam int unsigned REC_MAX_S  = 10;
    localparam int unsigned REC_DEF_S  = 1;
    localparam int unsigned DET_MAX_S  = 5;
    localparam int unsigned DET_DEF_S  = 1;
    localparam logic [TMW-1:0] REV_MIN_TK =
        TMW'(int'(REV_MIN_MIN * 60000.0 / TICK_MS));
    localparam logic [TMW-1:0] REV_MAX_TK =
        TMW'(int'(REV_MAX_MIN * 60000.0 / TICK_MS));
    localparam logic [TMW-1:0] REV_DEF_TK =
        TMW'(int'(REV_DEF_MIN * 60000.0 / TICK_MS));
    localparam logic [TMW-1:0] VER_MIN_TK = TMW'(VER_MIN_MS / TICK_MS);
    localparam logic [TMW-1:0] VER_MAX_TK = TMW'(VER_MAX_S * 1000 / TICK_MS);
    localparam logic [TMW-1:0] REC_MAX_TK = TMW'(REC_MAX_S * 1000 / TICK_MS);
    localparam logic [TMW-1:0] REC_DEF_TK = TMW'(REC_DEF_S * 1000 / TICK_MS);
    localparam logic [TMW-1:0] DET_MAX_TK = TMW'(DET_MAX_S * 1000 / TICK_MS);
    localparam logic [TMW-1:0] DET_DEF_TK = TMW'(DET_DEF_S * 1000 / TICK_MS);
    // register byte offsets
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_REV   = 8'h04;
    localparam logic [7:0] OFS_VER   = 8'h08;
    localparam logic [7:0] OFS_REC   = 8'h0C;
    localparam logic [7:0] OFS_DET   = 8'h10;
    localparam logic [7:0] OFS_CMD   = 8'h14;
    localparam logic [7:0] OFS_STAT  = 8'h18;
    localparam logic [7:0] OFS_WMASK = 8'h1C;
    // field positions
    localparam int unsigned CTRL_REVERT  = 0;
    localparam int unsigned CTRL_LOCKOUT = 1;
    localparam int unsigned CMD_FORCE    = 0;
    localparam int unsigned CMD_CLEAR    = 1;
    localparam int unsigned ST_DROP      = 7;
    // reset values
    localparam logic [1:0] CTRL_RST = 2'h0;
    // request codes in the k1 upper nibble, then bus response codes
    localparam logic [3:0] K1_REQ_NONE  = 4'h0;
    localparam logic [3:0] K1_REQ_FORCE = 4'hE;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // line defects of one port
    typedef struct packed {
        logic sd;
        logic sf;
        logic los;
        logic lof;
        logic ais;
    } lps_defect_s;
endpackage : lps_pkg

// ===== lps_tick.sv
// common tick generator
`timescale 1ns/1ps
module lps_tick
    import lps_pkg::*;
#(
    parameter int unsigned CYC = TICK_CYC
) (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic sys_rst_i,
    // one-cycle tick
    output logic      tick_o
);
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;

    // wrap once per tick
    always_comb begin
        tick_o   = (cnt_reg == 32'(CYC - 1));
        cnt_next = tick_o ? 32'h0 : cnt_reg + 32'h1;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 32'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : lps_tick

// ===== lps_timer.sv
// one interval timer
`timescale 1ns/1ps
module lps_timer
    import lps_pkg::*;
#(
    parameter int unsigned W = TMW
) (
    // clock and reset
    input  wire logic         sys_clk_i,
    input  wire logic         sys_rst_i,
    // tick, trigger level and limit
    input  wire logic         tick_i,
    input  wire logic         arm_i,
    input  wire logic [W-1:0] limit_i,
    // expiry pulse and running flag
    output logic              done_o,
    output logic              run_o
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         fired_reg;
    logic         fired_next;

    // count while armed, restart when disarmed
    always_comb begin
        done_o     = arm_i && !fired_reg && (cnt_reg >= limit_i);
        run_o      = arm_i && !fired_reg;
        cnt_next   = cnt_reg;
        fired_next = fired_reg;
        if (!arm_i) begin
            cnt_next   = '0;
            fired_next = 1'b0;
        end else if (done_o) begin
            fired_next = 1'b1;
        end else if (tick_i && !fired_reg) begin
            cnt_next = cnt_reg + W'(1);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            cnt_reg   <= '0;
            fired_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            fired_reg <= fired_next;
        end
    end
endmodule : lps_timer

// ===== lps_far_end.sv
// far-end node model answering force requests
`timescale 1ns/1ps
module lps_far_end
    import lps_pkg::*;
(
    // clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    // acknowledge enable and answer delay
    input  wire logic       ack_en_i,
    input  wire logic [3:0] dly_i,
    // k1 bytes
    input  wire logic [7:0] tx_k1_i,
    output logic      [7:0] rx_k1_o
);
    logic       req;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic       ack;
    // age of the force request
    always_comb begin
        req      = (tx_k1_i[7:4] == K1_REQ_FORCE);
        cnt_next = 4'h0;
        if (req && cnt_reg != dly_i) begin
            cnt_next = cnt_reg + 4'h1;
        end else if (req) begin
            cnt_next = cnt_reg;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        cnt_reg <= sys_rst_i ? 4'h0 : cnt_next;
    end
    // acknowledge late or never
    assign ack = ack_en_i && req && cnt_reg == dly_i;
    assign rx_k1_o = {ack ? K1_REQ_FORCE : K1_REQ_NONE, 4'h0};
endmodule : lps_far_end

// ===== linear_protection_switch_ctrl_test.sv
// bench of the protection switch controller
`timescale 1ns/1ps
module linear_protection_switch_ctrl_test;
    import lps_pkg::*;
    localparam int TK = 4;
    localparam int DT = 3;
    localparam int RC = 2;
    localparam int RV = int'(REV_MIN_TK);
    localparam int VR = int'(VER_MIN_TK);
    logic              sys_clk, sys_rst, ack_en;
    logic [7:0]        awaddr, araddr, rx_k1, tx_k1;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, sel_prot;
    logic [31:0]       wdata, rdata, d;
    logic [1:0]        bresp, rresp;
    lps_defect_s [1:0] wdef;
    lps_defect_s       pdef;
    int                err_total = 0;
    int                comparisons = 0;
    // design and far-end node
    lps_ctrl #(.NWORK(2), .TICK_CYCLES(TK)) DUT (
        .sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .work_defect_i(wdef), .prot_defect_i(pdef),
        .rx_k1_i(rx_k1), .tx_k1_o(tx_k1), .sel_prot_o(sel_prot));
    lps_far_end FAR (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst),
        .ack_en_i(ack_en), .dly_i(4'h3), .tx_k1_i(tx_k1), .rx_k1_o(rx_k1));
    task automatic chk(input logic [31:0] g, e,
                       input string m);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic complete_run;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic hang(input string m);
        err_total++;
        $display("wrong value at %0t: %s", $time, m);
        complete_run();
    endtask : hang
    // one write
    task automatic axw(input logic [7:0] a, input logic [31:0] v,
                       input logic [1:0] er);
        int n;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 50) hang("no bresp");
        chk(32'(bresp), 32'(er), "bresp");
    endtask : axw
    // one read
    task automatic axr(input logic [7:0] a, output logic [31:0] v,
                       input logic [1:0] er);
        int n;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        v = rdata;
        rready <= 1'b0;
        if (n == 50) hang("no rvalid");
        chk(32'(rresp), 32'(er), "rresp");
    endtask : axr
    // wait lo..hi cycles for selector or force code v
    task automatic wsel(input bit k, input logic v, input int lo, hi);
        int n;
        for (n = 0; n < hi; n++) begin
            if ((k ? tx_k1[7:4] === K1_REQ_FORCE : sel_prot) === v) break;
            @(posedge sys_clk);
        end
        if (n == hi) hang("timeout");
        chk(32'(n >= lo), 32'h1, "too early");
    endtask : wsel
    // reset values, clamping, unmapped place
    task automatic t_regs;
        logic [7:0]  ro [5] = '{OFS_CTRL, OFS_REV, OFS_VER, OFS_REC, OFS_DET};
        logic [12:0] re [5] = '{13'(CTRL_RST), REV_DEF_TK, VER_MAX_TK,
                                REC_DEF_TK, DET_DEF_TK};
        logic [7:0]  wo [8] = '{OFS_REV, OFS_REV, OFS_VER, OFS_VER,
                                OFS_REC, OFS_REC, OFS_DET, OFS_DET};
        logic [12:0] wv [8] = '{13'h1FFF, 13'h1, 13'hF, 13'h1,
                                13'h7F, 13'(RC), 13'h3F, 13'(DT)};
        logic [12:0] we [8] = '{REV_MAX_TK, REV_MIN_TK, VER_MAX_TK,
                                VER_MIN_TK, REC_MAX_TK, 13'(RC),
                                DET_MAX_TK, 13'(DT)};
        for (int i = 0; i < 5; i++) begin
            axr(ro[i], d, RESP_OKAY);
            chk(d, 32'(re[i]), "reset value");
        end
        for (int i = 0; i < 8; i++) begin
            axw(wo[i], 32'(wv[i]), RESP_OKAY);
            axr(wo[i], d, RESP_OKAY);
            chk(d, 32'(we[i]), "interval limit");
        end
        axr(8'h20, d, RESP_SLVERR);
        chk(d, 32'h0, "unmapped data");
        axw(8'h20, 32'h1, RESP_SLVERR);
        $display("test regs done");
    endtask : t_regs
    // guarded ports switch after a restarted guard
    task automatic t_detect;
        axw(OFS_WMASK, 32'h1, RESP_OKAY);
        wdef[1].sf <= 1'b1;
        repeat (40) @(posedge sys_clk);
        chk(32'(sel_prot), 32'h0, "unguarded switch");
        wdef[1] <= '0;
        wdef[0].los <= 1'b1;
        repeat (8) @(posedge sys_clk);
        wdef[0].los <= 1'b0;
        @(posedge sys_clk);
        wdef[0].los <= 1'b1;
        wsel(0, 1'b1, (DT - 1) * TK, (DT + 1) * TK + 8);
        chk(32'(tx_k1[0]), 32'h1, "k1 selector bit");
        $display("test detect done");
    endtask : t_detect
    // non-revertive hold, then reversion
    task automatic t_revert;
        wdef[0] <= '0;
        repeat (1400) @(posedge sys_clk);
        chk(32'(sel_prot), 32'h1, "left protect port");
        axr(OFS_STAT, d, RESP_OKAY);
        chk(32'(d[3]), 32'h0, "failure not cleared");
        chk(32'(d[6]), 32'h0, "reversion running");
        axw(OFS_CTRL, 32'h1 << CTRL_REVERT, RESP_OKAY);
        wsel(0, 1'b0, (RV - 1) * TK, (RV + 2) * TK + 10);
        wdef[0].sd <= 1'b1;
        wsel(0, 1'b1, (DT - 1) * TK, (DT + 1) * TK + 8);
        wdef[0] <= '0;
        wsel(0, 1'b0, (RC + RV - 2) * TK, (RC + RV + 2) * TK + 10);
        $display("test revert done");
    endtask : t_revert
    // force dropped, refused, then acknowledged
    task automatic t_force;
        axw(OFS_CTRL, 32'h0, RESP_OKAY);
        axw(OFS_CMD, 32'h1 << CMD_FORCE, RESP_OKAY);
        chk(32'(tx_k1[7:4]), 32'(K1_REQ_FORCE), "force not sent");
        wsel(1, 1'b0, (VR - 1) * TK, (VR + 1) * TK + 8);
        axr(OFS_STAT, d, RESP_OKAY);
        chk(32'(d[ST_DROP]), 32'h1, "drop flag");
        axw(OFS_STAT, 32'h1 << ST_DROP, RESP_OKAY);
        axr(OFS_STAT, d, RESP_OKAY);
        chk(32'(d[ST_DROP]), 32'h0, "drop flag cleared");
        axw(OFS_CTRL, 32'h1 << CTRL_LOCKOUT, RESP_OKAY);
        pdef.sf <= 1'b1;
        repeat (4) @(posedge sys_clk);
        axw(OFS_CMD, 32'h1 << CMD_FORCE, RESP_OKAY);
        chk(32'(tx_k1), 32'h0, "force under lockout");
        pdef <= '0;
        ack_en <= 1'b1;
        repeat (4) @(posedge sys_clk);
        axw(OFS_CMD, 32'h1 << CMD_FORCE, RESP_OKAY);
        chk(32'(tx_k1[7:4]), 32'(K1_REQ_FORCE), "force refused");
        repeat ((VR + 3) * TK) @(posedge sys_clk);
        chk(32'(tx_k1[7:4]), 32'(K1_REQ_FORCE), "acked force lost");
        chk(32'(sel_prot), 32'h1, "force not on protect");
        axr(OFS_STAT, d, RESP_OKAY);
        chk(32'(d[2:1]), 32'h2, "force not active");
        axw(OFS_CMD, 32'h1 << CMD_CLEAR, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        chk(32'(tx_k1[7:4]), 32'(K1_REQ_NONE), "force not cleared");
        $display("test force done");
    endtask : t_force
    // clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // main sequence
    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready, ack_en} = '0;
        wdef = '0;
        pdef = '0;
        sys_rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_detect();
        t_revert();
        t_force();
        complete_run();
    end
endmodule : linear_protection_switch_ctrl_test
